// ---- pkg/cij_regs.svh ----
`ifndef CIJ_REGS_SVH
`define CIJ_REGS_SVH

// ==========================================================
// instruction word fields
`define CIJ_OP_MSB      31
`define CIJ_OP_LSB      26
`define CIJ_SRC_MSB     25
`define CIJ_SRC_LSB     21
`define CIJ_BASE_MSB    20
`define CIJ_BASE_LSB    16
`define CIJ_OFF_MSB     15
`define CIJ_OFF_LSB     0

// ==========================================================
// encodings
`define CIJ_OP_LINK     6'h3e
`define CIJ_OP_NOLINK   6'h36
`define CIJ_SRC_JUMP    5'h00
`define CIJ_LINK_REG    5'h1f
`define CIJ_ISA_NONE    2'h0

// ==========================================================
// reset values and sizes
`define CIJ_INSN_BYTES  64'h0000000000000004
`define CIJ_ADDR_RST    64'h0000000000000000
`define CIJ_ISA_RST     1'h0

`endif

// ---- pkg/cij_pkg.sv ----
package cij_pkg;

  // ========================================================
  // sequencer states
  typedef enum logic [0:0] {
    CIJ_ST_IDLE  = 1'b0,
    CIJ_ST_REDIR = 1'b1
  } cij_state_t;

  // ========================================================
  // kind of the jump being issued
  typedef enum logic [1:0] {
    CIJ_KIND_NONE   = 2'b00,
    CIJ_KIND_LINK   = 2'b01,
    CIJ_KIND_NOLINK = 2'b10
  } cij_kind_t;

  // ========================================================
  // whole state of the jump unit
  typedef struct packed {
    cij_state_t  state;
    cij_kind_t   kind;
    logic        redirVld;
    logic [63:0] target;
    logic        instruction_set_select_bit;
    logic        addrErr;
    logic        linkWe;
    logic [63:0] linkData;
  } cij_jstate_t;

endpackage

// ---- hdl/cij_target_calc.sv ----
`timescale 1ns/10ps
`include "cij_regs.svh"

module cij_target_calc (
  // operands
  input  wire logic [63:0] baseVal,
  input  wire logic [15:0] offset,
  input  wire logic        compressedImpl,
  // result
  output logic      [63:0] target,
  output logic             isaBit,
  output logic             misaligned
);

  logic [63:0] sum;

  // offset added bit for bit, no left shift
  assign sum = baseVal + {{48{offset[15]}}, offset};

  // ========================================================
  // mode select from bit 0, or full sum when single isa
  assign target = compressedImpl ? {sum[63:1], 1'b0} : sum;
  assign isaBit = compressedImpl & sum[0];

  // ========================================================
  // only a word-mode target must be word aligned
  assign misaligned = compressedImpl ? (~sum[0] & sum[1])
                                     : (|sum[1:0]);

endmodule // cij_target_calc

// ---- hdl/cij_jump_unit.sv ----
`timescale 1ns/10ps
`include "cij_regs.svh"

// Overview of operation
// - linking jump: opcode 111110, source 00000, base and 16-bit offset.
// - non-linking jump: own opcode, source 00000, base and 16-bit offset.
// - target is base plus sign-extended offset, offset never shifted.
// - linking jump writes current address plus 4 into register 31.
// - base is read before link write, so base 31 uses old value.
// - both jumps always taken; next sequential instruction never runs.
// - no delay or forbidden slot; next instruction comes from the target.
// - single isa: sum is target; unaligned word gives fetch address error.
// - compressed isa: mode bit loads from sum bit 0, target bit 0 cleared.
// - compressed isa, mode 0: unaligned target gives fetch address error.
// - linking jump told from branch-not-zero only by bits 25 to 21.
// - non-linking jump told from branch-equal-zero only by source field.
// - both jumps always present, no option removes them.

module cij_jump_unit
  import cij_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // core configuration
  input  wire logic [1:0]  implementedIsaField,
  input  wire logic        compressedAsePresentFlag,
  // decode side
  input  wire logic        instrValid,
  input  wire logic [31:0] instrWord,
  input  wire logic [63:0] instrPc,
  output logic             instrReady,
  output logic             instrOther,
  // general register read port
  output logic      [4:0]  gprRdIdx,
  input  wire logic [63:0] gprRdData,
  // general register write port
  output logic             gprWrEn,
  output logic      [4:0]  gprWrIdx,
  output logic      [63:0] gprWrData,
  // fetch redirect
  output logic             redirValid,
  output logic      [63:0] redirPc,
  output logic             redirAddrErr,
  output logic             squashSeq,
  output logic             isaModeOut
);

  // ========================================================
  // state
  cij_jstate_t st_reg;
  cij_jstate_t st_next;

  // ========================================================
  // decode
  logic [5:0]  opField;
  logic [4:0]  srcField;
  logic [4:0]  baseField;
  logic [15:0] offField;
  logic        isLink;
  logic        isNoLink;
  logic        isJump;
  logic        take;
  logic        compressedImpl;
  logic [63:0] calcTarget;
  logic        calcIsa;
  logic        calcMisaligned;

  assign opField   = instrWord[`CIJ_OP_MSB:`CIJ_OP_LSB];
  assign srcField  = instrWord[`CIJ_SRC_MSB:`CIJ_SRC_LSB];
  assign baseField = instrWord[`CIJ_BASE_MSB:`CIJ_BASE_LSB];
  assign offField  = instrWord[`CIJ_OFF_MSB:`CIJ_OFF_LSB];

  // shared opcodes: a nonzero source field means a compact branch
  assign isLink   = (opField == `CIJ_OP_LINK)
                  & (srcField == `CIJ_SRC_JUMP);
  assign isNoLink = (opField == `CIJ_OP_NOLINK)
                  & (srcField == `CIJ_SRC_JUMP);
  // no enable input: decode cannot be switched off
  assign isJump = isLink | isNoLink;

  // the slot after a jump is refused while redirecting
  assign instrReady = (st_reg.state == CIJ_ST_IDLE);
  assign take       = instrValid & instrReady & isJump;
  assign instrOther = instrValid & instrReady & ~isJump;

  // base read combinationally in the decode cycle
  assign gprRdIdx = baseField;

  assign compressedImpl = (implementedIsaField != `CIJ_ISA_NONE)
                        | compressedAsePresentFlag;

  // ========================================================
  // target arithmetic
  cij_target_calc u_calc (
    .baseVal        (gprRdData),
    .offset         (offField),
    .compressedImpl (compressedImpl),
    .target         (calcTarget),
    .isaBit         (calcIsa),
    .misaligned     (calcMisaligned)
  );

  // ========================================================
  // next state
  always_comb begin
    st_next          = st_reg;
    st_next.redirVld = 1'b0;
    st_next.linkWe   = 1'b0;
    case (st_reg.state)
      CIJ_ST_IDLE: begin
        if (take) begin
          st_next.state    = CIJ_ST_REDIR;
          st_next.redirVld = 1'b1;
          st_next.kind     = isLink ? CIJ_KIND_LINK : CIJ_KIND_NOLINK;
          st_next.target   = calcTarget;
          st_next.addrErr  = calcMisaligned;
          if (compressedImpl) begin
            st_next.instruction_set_select_bit = calcIsa;
          end
          // link written a cycle after base was read
          st_next.linkWe   = isLink;
          st_next.linkData = instrPc + `CIJ_INSN_BYTES;
        end
      end
      CIJ_ST_REDIR: begin
        st_next.state = CIJ_ST_IDLE;
        st_next.kind  = CIJ_KIND_NONE;
      end
      default: begin
        st_next.state = CIJ_ST_IDLE;
        st_next.kind  = CIJ_KIND_NONE;
      end
    endcase
  end

  // ========================================================
  // registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_reg.state    <= CIJ_ST_IDLE;
      st_reg.kind     <= CIJ_KIND_NONE;
      st_reg.redirVld <= 1'b0;
      st_reg.target   <= `CIJ_ADDR_RST;
      st_reg.instruction_set_select_bit  <= `CIJ_ISA_RST;
      st_reg.addrErr  <= 1'b0;
      st_reg.linkWe   <= 1'b0;
      st_reg.linkData <= `CIJ_ADDR_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ========================================================
  // outputs
  assign redirValid   = st_reg.redirVld;
  assign redirPc      = st_reg.target;
  assign redirAddrErr = st_reg.redirVld & st_reg.addrErr;
  // the sequential instruction already fetched is dropped
  assign squashSeq    = st_reg.redirVld;
  assign isaModeOut   = st_reg.instruction_set_select_bit;
  assign gprWrEn      = st_reg.linkWe;
  assign gprWrIdx     = `CIJ_LINK_REG;
  assign gprWrData    = st_reg.linkData;

  // ========================================================
  // checks
  logic [63:0] expSum;
  assign expSum = gprRdData + {{48{offField[15]}}, offField};

  chk_link_decode: assert property (
    @(posedge mclk) disable iff (!rstn)
    (take && opField == `CIJ_OP_LINK) |=> (gprWrEn && redirValid)
  ) else $error("linking jump did not write link");

  chk_nolink_decode: assert property (
    @(posedge mclk) disable iff (!rstn)
    (take && opField == `CIJ_OP_NOLINK) |=> (redirValid && !gprWrEn)
  ) else $error("plain jump redirect wrong");

  chk_target_sum: assert property (
    @(posedge mclk) disable iff (!rstn)
    (take && !compressedImpl) |=> (redirPc == $past(expSum))
  ) else $error("target is not base plus offset");

  chk_link_value: assert property (
    @(posedge mclk) disable iff (!rstn)
    gprWrEn |-> (gprWrIdx == 5'h1f
                 && gprWrData == $past(instrPc) + 64'h4)
  ) else $error("link value wrong");

  chk_base_old: assert property (
    @(posedge mclk) disable iff (!rstn)
    take |-> !gprWrEn ##1 (redirPc[63:1] == $past(expSum[63:1]))
  ) else $error("base not read before link write");

  chk_squash_seq: assert property (
    @(posedge mclk) disable iff (!rstn)
    take |=> (squashSeq && !instrReady) ##1 instrReady
  ) else $error("sequential slot not squashed");

  chk_no_slot: assert property (
    @(posedge mclk) disable iff (!rstn)
    redirValid |=> (!redirValid && instrReady)
  ) else $error("jump held a slot");

  chk_single_isa: assert property (
    @(posedge mclk) disable iff (!rstn)
    (take && !compressedImpl) |=>
      (redirAddrErr == ($past(expSum[1:0]) != 2'h0))
  ) else $error("single isa alignment error wrong");

  chk_mode_bit: assert property (
    @(posedge mclk) disable iff (!rstn)
    (take && compressedImpl) |=>
      (isaModeOut == $past(expSum[0]) && redirPc[0] == 1'b0)
  ) else $error("mode bit or target bit 0 wrong");

  chk_word_mode: assert property (
    @(posedge mclk) disable iff (!rstn)
    (redirValid && !isaModeOut && redirPc[1] && $past(compressedImpl))
      |-> redirAddrErr
  ) else $error("word mode misalignment not flagged");

  chk_branch_pass: assert property (
    @(posedge mclk) disable iff (!rstn)
    (instrValid && instrReady && srcField != 5'h00) |->
      (instrOther ##1 !redirValid)
  ) else $error("compact branch taken as jump");

  chk_nolink_regs: assert property (
    @(posedge mclk) disable iff (!rstn)
    (st_reg.kind == CIJ_KIND_NOLINK) |-> !gprWrEn
  ) else $error("plain jump wrote a register");

  chk_nolink_branch: assert property (
    @(posedge mclk) disable iff (!rstn)
    (instrValid && instrReady && opField == `CIJ_OP_NOLINK
     && srcField != 5'h00) |-> (instrOther ##1 !redirValid)
  ) else $error("branch-equal-zero taken as jump");

  chk_jump_always: assert property (
    @(posedge mclk) disable iff (!rstn)
    (instrValid && instrReady && srcField == 5'h00
     && (opField == `CIJ_OP_LINK || opField == `CIJ_OP_NOLINK))
      |-> (!instrOther ##1 redirValid)
  ) else $error("jump word not executed");

  chk_redir_cause: assert property (
    @(posedge mclk) disable iff (!rstn)
    redirValid |-> ($past(take) && squashSeq)
  ) else $error("redirect without a taken jump");

  chk_refused_idle: assert property (
    @(posedge mclk) disable iff (!rstn)
    !instrReady |-> (!instrOther ##1 !redirValid)
  ) else $error("refused slot acted on");

  chk_target_hold: assert property (
    @(posedge mclk) disable iff (!rstn)
    !redirValid |-> $stable(redirPc)
  ) else $error("target changed without redirect");

  chk_mode_hold: assert property (
    @(posedge mclk) disable iff (!rstn)
    !redirValid |-> $stable(isaModeOut)
  ) else $error("mode bit changed without redirect");

  chk_single_keep: assert property (
    @(posedge mclk) disable iff (!rstn)
    (take && !compressedImpl) |=> $stable(isaModeOut)
  ) else $error("single isa changed the mode bit");

  chk_err_pulse: assert property (
    @(posedge mclk) disable iff (!rstn)
    redirAddrErr |-> redirValid
  ) else $error("address error outside a redirect");

  chk_word_err: assert property (
    @(posedge mclk) disable iff (!rstn)
    (redirValid && isaModeOut && $past(compressedImpl)) |->
      !redirAddrErr
  ) else $error("compressed target flagged misaligned");

  chk_link_pulse: assert property (
    @(posedge mclk) disable iff (!rstn)
    gprWrEn |-> (redirValid && $past(take)
                 && $past(opField) == `CIJ_OP_LINK)
  ) else $error("link write without a linking jump");

  chk_link_once: assert property (
    @(posedge mclk) disable iff (!rstn)
    gprWrEn |=> !gprWrEn
  ) else $error("link write lasted too long");

  chk_ready_after: assert property (
    @(posedge mclk) disable iff (!rstn)
    redirValid |-> !instrReady
  ) else $error("offer accepted during redirect");

  chk_split_target: assert property (
    @(posedge mclk) disable iff (!rstn)
    (take && compressedImpl) |=>
      (redirPc == {$past(expSum[63:1]), 1'b0})
  ) else $error("compressed target wrong");

endmodule // cij_jump_unit

// ---- dv/cij_gpr_model.sv ----
`timescale 1ns/10ps

// ==========================================
// general register file seen by the jump unit
module cij_gpr_model (
  // clock
  input  wire logic        mclk,
  // read port
  input  wire logic [4:0]  rdIdx,
  output logic      [63:0] rdData,
  // write port
  input  wire logic        wrEn,
  input  wire logic [4:0]  wrIdx,
  input  wire logic [63:0] wrData
);
  // plain array so the bench can preload it
  logic [63:0] regs [32];

  // combinational read, so base 31 sees the old value
  assign rdData = (rdIdx == 5'h00) ? 64'h0 : regs[rdIdx];

  always @(posedge mclk) begin
    if (wrEn) regs[wrIdx] <= wrData;
  end
endmodule // cij_gpr_model

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
`include "cij_regs.svh"

module testbench;
  // ==========================================
  // signals
  logic        mclk;
  logic        rstn;
  logic [1:0]  implementedIsaField;
  logic        compressedAsePresentFlag;
  logic        instrValid;
  logic [31:0] instrWord;
  logic [63:0] instrPc;
  logic        instrReady;
  logic        instrOther;
  logic [4:0]  gprRdIdx;
  logic [63:0] gprRdData;
  logic        gprWrEn;
  logic [4:0]  gprWrIdx;
  logic [63:0] gprWrData;
  logic        redirValid;
  logic [63:0] redirPc;
  logic        redirAddrErr;
  logic        squashSeq;
  logic        isaModeOut;
  int          failures;
  int          checks;
  logic        expIsa;

  typedef struct {
    logic [63:0] pc;
    logic        err;
    logic        isa;
    logic        link;
    logic [63:0] ld;
  } cij_exp_t;
  cij_exp_t    expQ[$];

  // ==========================================
  // instances
  cij_jump_unit i_dut (
    .mclk(mclk), .rstn(rstn),
    .implementedIsaField(implementedIsaField),
    .compressedAsePresentFlag(compressedAsePresentFlag),
    .instrValid(instrValid), .instrWord(instrWord), .instrPc(instrPc),
    .instrReady(instrReady), .instrOther(instrOther),
    .gprRdIdx(gprRdIdx), .gprRdData(gprRdData),
    .gprWrEn(gprWrEn), .gprWrIdx(gprWrIdx), .gprWrData(gprWrData),
    .redirValid(redirValid), .redirPc(redirPc),
    .redirAddrErr(redirAddrErr), .squashSeq(squashSeq),
    .isaModeOut(isaModeOut)
  );

  cij_gpr_model i_gpr (
    .mclk(mclk), .rdIdx(gprRdIdx), .rdData(gprRdData),
    .wrEn(gprWrEn), .wrIdx(gprWrIdx), .wrData(gprWrData)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ==========================================
  // checking and closing
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================
  // driver: one offer, a jump also spends its refused cycle
  task automatic offer(input logic lnk, input logic [4:0] src,
      input logic [4:0] b, input logic [15:0] off, input logic [63:0] pc,
      input logic hold);
    cij_exp_t    e;
    logic [63:0] s;
    logic        jmp;
    jmp = (src == `CIJ_SRC_JUMP);
    instrValid = 1'b1;
    instrWord = {(lnk ? `CIJ_OP_LINK : `CIJ_OP_NOLINK), src, b, off};
    instrPc = pc;
    s = (b == 5'h00 ? 64'h0 : i_gpr.regs[b]) + {{48{off[15]}}, off};
    e.link = lnk;
    e.ld = pc + 64'h4;
    if (implementedIsaField != 2'h0 || compressedAsePresentFlag) begin
      e.pc = {s[63:1], 1'b0};
      e.isa = s[0];
      e.err = !s[0] && s[1];
    end else begin
      e.pc = s;
      e.isa = expIsa;
      e.err = s[1:0] != 2'h0;
    end
    #1;
    check(64'(instrOther), 64'(!jmp));
    if (jmp) begin
      expIsa = e.isa;
      expQ.push_back(e);
    end
    @(negedge mclk);
    if (jmp) begin
      // a held word here must be ignored, not taken twice
      check(64'(instrReady), 64'h0);
      instrValid = hold;
      @(negedge mclk);
    end
  endtask

  // ==========================================
  // monitor: each redirect takes the oldest note
  initial begin : mon
    cij_exp_t e;
    forever begin
      @(negedge mclk);
      if (redirValid === 1'b1) begin
        if (expQ.size() == 0) begin
          check(64'h1, 64'h0);
        end else begin
          e = expQ.pop_front();
          check(redirPc, e.pc);
          check(64'(redirAddrErr), 64'(e.err));
          check(64'(isaModeOut), 64'(e.isa));
          check(64'(squashSeq), 64'h1);
          check(64'(gprWrEn), 64'(e.link));
          if (e.link) check(gprWrData, e.ld);
          if (e.link) check(64'(gprWrIdx), 64'h1f);
        end
      end else if (rstn === 1'b1) begin
        check(64'({gprWrEn, squashSeq, redirAddrErr}), 64'h0);
      end
    end
  end

  // ==========================================
  // main sequence
  initial begin
    logic [1:0] k;
    failures = 0;
    checks = 0;
    expIsa = 1'b0;
    rstn = 1'b0;
    instrValid = 1'b0;
    instrWord = 32'h0;
    instrPc = 64'h0;
    implementedIsaField = 2'h0;
    compressedAsePresentFlag = 1'b0;
    void'($urandom(8));
    for (int i = 1; i < 32; i++) i_gpr.regs[i] = {$urandom, $urandom};
    repeat (3) @(negedge mclk);
    check(64'({redirValid, gprWrEn, isaModeOut, instrReady}), 64'h1);
    rstn = 1'b1;
    @(negedge mclk);
    for (int c = 0; c < 8; c++) begin
      implementedIsaField = c[1:0];
      compressedAsePresentFlag = c[2];
      // base 31 twice: second must see the first link value
      offer(1'b1, 5'h00, 5'h1f, 16'h0001, 64'h40, 1'b1);
      offer(1'b1, 5'h00, 5'h1f, 16'hfffe, 64'h80, 1'b0);
      for (int n = 0; n < 12; n++) begin
        k = 2'($urandom);
        offer(k[0], k[1] ? 5'(1 + $urandom % 31) : 5'h00, 5'($urandom),
              16'($urandom), {$urandom, $urandom & 32'hfffffffc},
              1'($urandom));
      end
    end
    instrValid = 1'b0;
    repeat (4) @(negedge mclk);
    check(64'(expQ.size()), 64'h0);
    results();
  end

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #20000;
    failures++;
    results();
  end
endmodule // testbench
